// file: core/e1_mon_pkg.sv
// Constants, register map and carrier types for the E1 receive performance monitor
// Contract
// - Single all-clear flag while nothing is detected
// - Count seconds with loss of signal
// - Count seconds with loss of framing
// - Count code violations; supply code error rate
// - Count seconds of alarm and remote defect forms
// - Count alignment word errors after first frame sync
// - Count local CRC errors and remote E-bit errors
// - Count pattern bit errors and errored blocks
// - Count pattern slips and post-sync sync losses
// - Flag frequency deviation beyond 50 ppm
// - Sticky history per live flag, cleared on restart except flags still live
// - Accumulate signal results incl. loss-of-signal alarms
// - Report current and maximum deviation, 200 ppm range
// - Signed bit slip count wrapping at 255
// - Bit slip count zeroed when either signal lost
// - Positive slip when analysed signal runs faster
// - Count frame slips as unsigned magnitude
package e1_mon_pkg;

  // ****************************************************************
  // Timing and measurement
  // ****************************************************************
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned TICK_SECONDS = 1;
  localparam int unsigned SEC_CYCLES_DEF = CLK_HZ * TICK_SECONDS;
  localparam int unsigned NOM_KBPS = 2048;
  localparam int unsigned NOM_BITS_DEF = NOM_KBPS * 1000 * TICK_SECONDS;
  localparam logic [9:0] TOL_PPM = 10'h032;
  localparam logic signed [9:0] RANGE_PPM = 10'sh0c8;
  // 1 ppm of 2048 kbit/s is 2.048 bit/s, so ppm = diff * 125 / 256
  localparam logic signed [39:0] PPM_MUL = 40'sh00_0000_007d;
  localparam int unsigned PPM_SHIFT = 8;
  localparam logic signed [8:0] SLIP_MAX = 9'sh0ff;
  localparam logic signed [8:0] SLIP_MIN = -9'sh0ff;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic los;
    logic lof;
    logic sequence_sync_lost;
    logic fas_sync;
    logic mfas_sync;
    logic crc_sync;
    logic ais;
    logic rdi;
    logic mf_ais;
    logic mf_rdi;
  } live_t;

  typedef struct packed {
    logic code_err;
    logic fas_err;
    logic mfas_err;
    logic crc_err;
    logic ebit_err;
    logic pat_err;
    logic block_end;
    logic pat_slip;
  } ev_t;

  localparam int unsigned LIVE_W = $bits(live_t);
  localparam int unsigned EV_W = $bits(ev_t);
  // Live flags that count against the all-clear indication
  localparam logic [9:0] HIST_BAD = 10'h38f;

  // ****************************************************************
  // Counters
  // ****************************************************************
  localparam int unsigned C_LOS_SEC = 0;
  localparam int unsigned C_LOF_SEC = 1;
  localparam int unsigned C_CODE = 2;
  localparam int unsigned C_AIS_SEC = 3;
  localparam int unsigned C_RDI_SEC = 4;
  localparam int unsigned C_MFAIS_SEC = 5;
  localparam int unsigned C_MFRDI_SEC = 6;
  localparam int unsigned C_FAS_WORD = 7;
  localparam int unsigned C_MFAS_WORD = 8;
  localparam int unsigned C_CRC = 9;
  localparam int unsigned C_EBIT = 10;
  localparam int unsigned C_PAT_BIT = 11;
  localparam int unsigned C_BLOCK = 12;
  localparam int unsigned C_PAT_SLIP = 13;
  localparam int unsigned C_SYNC_LOSS = 14;
  localparam int unsigned C_LOS_ALARM = 15;
  localparam int unsigned C_RX_BITS = 16;
  localparam int unsigned C_FRAME_SLIP = 17;
  localparam int unsigned NUM_CNT = 18;
  localparam logic [NUM_CNT-1:0] ERR_CNT_MASK = 18'h2ffff;

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam int unsigned AW = 12;
  localparam logic [AW-1:0] A_CTRL = 12'h000;
  localparam logic [AW-1:0] A_LIVE = 12'h004;
  localparam logic [AW-1:0] A_HIST = 12'h008;
  localparam logic [AW-1:0] A_IRQ_ST = 12'h00c;
  localparam logic [AW-1:0] A_IRQ_MASK = 12'h010;
  localparam logic [AW-1:0] A_DEV = 12'h014;
  localparam logic [AW-1:0] A_MAX_DEV = 12'h018;
  localparam logic [AW-1:0] A_BIT_SLIP = 12'h01c;
  localparam logic [AW-1:0] A_CNT_BASE = 12'h040;
  localparam int unsigned CTRL_RESTART = 0;
  localparam int unsigned LIVE_ALL_CLEAR = 10;
  localparam int unsigned LIVE_OOT = 11;

  // Interrupt status bits
  localparam int unsigned I_LOS = 0;
  localparam int unsigned I_LOF = 1;
  localparam int unsigned I_SYNC_LOSS = 2;
  localparam int unsigned I_ERR = 3;
  localparam int unsigned I_OOT = 4;
  localparam int unsigned I_SLIP = 5;
  localparam int unsigned IRQ_W = 6;

endpackage : e1_mon_pkg

// file: core/e1_perf_monitor.sv
// E1 receive performance monitor: counters, history, slips, frequency and APB registers
//
// Added by the designer: the address map and register access over APB.
`timescale 1ns/1ps
module e1_perf_monitor import e1_mon_pkg::*; #(
  parameter logic [31:0] SEC_CYCLES = SEC_CYCLES_DEF,
  parameter logic [31:0] NOM_BITS = NOM_BITS_DEF
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_clk_pin,
  input wire logic ref_clk_pin,
  input wire logic ref_los,
  input wire live_t live_in,
  input wire ev_t ev_in,
  output logic irq,
  output logic all_clear
);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  localparam int unsigned SYNC_W = 3 + LIVE_W + EV_W;
  logic [SYNC_W-1:0] sync1_r;
  logic [SYNC_W-1:0] sync2_r;
  logic rx_d_r;
  logic ref_d_r;
  logic rx_rise;
  logic ref_rise;
  logic ref_lost;
  live_t live;
  live_t live_prev_r;
  ev_t ev_raw;
  ev_t ev;

  always_ff @(posedge clock) begin
    sync1_r <= {rx_clk_pin, ref_clk_pin, ref_los, live_in, ev_in};
    sync2_r <= sync1_r;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rx_d_r <= 1'b0;
      ref_d_r <= 1'b0;
      live_prev_r <= '0;
    end else begin
      rx_d_r <= sync2_r[SYNC_W-1];
      ref_d_r <= sync2_r[SYNC_W-2];
      live_prev_r <= live;
    end
  end

  always_comb begin
    ref_lost = sync2_r[SYNC_W-3];
    live = sync2_r[LIVE_W+EV_W-1:EV_W];
    ev_raw = sync2_r[EV_W-1:0];
    rx_rise = sync2_r[SYNC_W-1] & ~rx_d_r;
    ref_rise = sync2_r[SYNC_W-2] & ~ref_d_r;
    // Event strobes are only meaningful at a receive bit edge
    ev = rx_rise ? ev_raw : '0;
  end

  // ****************************************************************
  // APB slave
  // ****************************************************************
  logic wr_en;
  logic restart;
  logic [IRQ_W-1:0] irq_mask_r;
  logic [IRQ_W-1:0] irq_st_r;
  logic [IRQ_W-1:0] irq_ev;
  logic [31:0] rd_data;
  logic rd_hit;
  logic [31:0] cnt_r [NUM_CNT];
  live_t hist_r;
  logic signed [9:0] dev_r;
  logic [9:0] max_dev_r;
  logic signed [8:0] slip_r;
  logic oot_r;
  logic [AW-1:0] cnt_off;

  // Zero wait states: pready rises in the first access cycle
  assign wr_en = psel & penable & pready & pwrite;
  assign restart = wr_en & (paddr == A_CTRL) & pwdata[CTRL_RESTART];

  always_comb begin
    rd_data = '0;
    rd_hit = 1'b1;
    cnt_off = paddr - A_CNT_BASE;
    case (paddr)
      A_CTRL: rd_data = '0;
      A_LIVE: rd_data = {20'h0_0000, oot_r, all_clear, live};
      A_HIST: rd_data = {22'h00_0000, hist_r};
      A_IRQ_ST: rd_data = {26'h000_0000, irq_st_r};
      A_IRQ_MASK: rd_data = {26'h000_0000, irq_mask_r};
      A_DEV: rd_data = {{22{dev_r[9]}}, dev_r};
      A_MAX_DEV: rd_data = {22'h00_0000, max_dev_r};
      A_BIT_SLIP: rd_data = {{23{slip_r[8]}}, slip_r};
      default: begin
        if (paddr >= A_CNT_BASE && cnt_off[AW-1:2] < AW'(NUM_CNT) && paddr[1:0] == 2'h0) begin
          rd_data = cnt_r[cnt_off[6:2]];
        end else begin
          rd_hit = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~rd_hit;
      if (psel & ~penable & ~pwrite) begin
        prdata <= rd_data;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      irq_mask_r <= '0;
    end else if (wr_en & (paddr == A_IRQ_MASK)) begin
      irq_mask_r <= pwdata[IRQ_W-1:0];
    end
  end

  // ****************************************************************
  // One-second tick
  // ****************************************************************
  logic [31:0] tick_cnt_r;
  logic tick;

  always_ff @(posedge clock) begin
    if (sys_rst || tick_cnt_r == SEC_CYCLES - 32'h1) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h1;
    end
  end
  assign tick = (tick_cnt_r == SEC_CYCLES - 32'h1);

  // ****************************************************************
  // Test state: history, first sync, per-second presence
  // ****************************************************************
  logic frame_once_r;
  logic pat_once_r;
  logic blk_seen_r;
  logic [5:0] sec_seen_r;
  logic [5:0] sec_now;
  logic sync_loss_ev;

  assign sec_now = {live.mf_rdi, live.mf_ais, live.rdi, live.ais, live.lof, live.los};
  assign sync_loss_ev = live.sequence_sync_lost & ~live_prev_r.sequence_sync_lost & pat_once_r;

  // A flag still live at restart stays set, so the clear never hides it
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      hist_r <= '0;
    end else if (restart) begin
      hist_r <= live;
    end else begin
      hist_r <= hist_r | live;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst || restart) begin
      frame_once_r <= 1'b0;
      pat_once_r <= 1'b0;
    end else begin
      frame_once_r <= frame_once_r | live.fas_sync;
      pat_once_r <= pat_once_r | ~live.sequence_sync_lost;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst || restart || tick) begin
      sec_seen_r <= '0;
    end else begin
      sec_seen_r <= sec_seen_r | sec_now;
    end
  end

  // A block is errored if any pattern bit in it was errored
  always_ff @(posedge clock) begin
    if (sys_rst || restart || ev.block_end) begin
      blk_seen_r <= 1'b0;
    end else if (ev.pat_err) begin
      blk_seen_r <= 1'b1;
    end
  end

  // ****************************************************************
  // Bit and frame slips against the reference
  // ****************************************************************
  logic both_present;
  logic slip_up;
  logic slip_dn;
  logic frame_slip_ev;

  assign both_present = ~live.los & ~ref_lost;
  // Coincident edges cancel, so only a net phase step moves the count
  assign slip_up = rx_rise & ~ref_rise;
  assign slip_dn = ref_rise & ~rx_rise;
  // A full wrap of 256 bits is one frame's worth of slip
  assign frame_slip_ev = both_present & ((slip_up & slip_r == SLIP_MAX) | (slip_dn & slip_r == SLIP_MIN));

  always_ff @(posedge clock) begin
    if (sys_rst || !both_present) begin
      slip_r <= '0;
    end else if (slip_up) begin
      slip_r <= (slip_r == SLIP_MAX) ? '0 : slip_r + 9'sh001;
    end else if (slip_dn) begin
      slip_r <= (slip_r == SLIP_MIN) ? '0 : slip_r - 9'sh001;
    end
  end

  // ****************************************************************
  // Receive frequency deviation
  // ****************************************************************
  logic [31:0] edge_cnt_r;
  logic signed [39:0] diff_w;
  logic signed [39:0] scaled_w;
  logic signed [9:0] dev_nxt;
  logic [9:0] abs_nxt;

  always_ff @(posedge clock) begin
    if (sys_rst || tick) begin
      edge_cnt_r <= rx_rise ? 32'h1 : '0;
    end else if (rx_rise) begin
      edge_cnt_r <= edge_cnt_r + 32'h1;
    end
  end

  always_comb begin
    diff_w = $signed({8'h00, edge_cnt_r}) - $signed({8'h00, NOM_BITS});
    scaled_w = (diff_w * PPM_MUL) >>> PPM_SHIFT;
    if (scaled_w > 40'(RANGE_PPM)) begin
      dev_nxt = RANGE_PPM;
    end else if (scaled_w < -40'(RANGE_PPM)) begin
      dev_nxt = -RANGE_PPM;
    end else begin
      dev_nxt = scaled_w[9:0];
    end
    abs_nxt = dev_nxt[9] ? 10'(-dev_nxt) : 10'(dev_nxt);
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      dev_r <= '0;
      oot_r <= 1'b0;
    end else if (tick) begin
      dev_r <= dev_nxt;
      oot_r <= abs_nxt > TOL_PPM;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst || restart) begin
      max_dev_r <= '0;
    end else if (tick && abs_nxt > max_dev_r) begin
      max_dev_r <= abs_nxt;
    end
  end

  // ****************************************************************
  // Accumulating counters
  // ****************************************************************
  logic [NUM_CNT-1:0] cnt_inc;
  logic [5:0] sec_hit;

  assign sec_hit = (sec_seen_r | sec_now) & {6{tick}};

  always_comb begin
    cnt_inc = '0;
    cnt_inc[C_LOS_SEC] = sec_hit[0];
    cnt_inc[C_LOF_SEC] = sec_hit[1];
    cnt_inc[C_AIS_SEC] = sec_hit[2];
    cnt_inc[C_RDI_SEC] = sec_hit[3];
    cnt_inc[C_MFAIS_SEC] = sec_hit[4];
    cnt_inc[C_MFRDI_SEC] = sec_hit[5];
    cnt_inc[C_CODE] = ev.code_err;
    cnt_inc[C_FAS_WORD] = ev.fas_err & frame_once_r;
    cnt_inc[C_MFAS_WORD] = ev.mfas_err & frame_once_r;
    cnt_inc[C_CRC] = ev.crc_err;
    cnt_inc[C_EBIT] = ev.ebit_err;
    cnt_inc[C_PAT_BIT] = ev.pat_err;
    cnt_inc[C_BLOCK] = ev.block_end & (blk_seen_r | ev.pat_err);
    cnt_inc[C_PAT_SLIP] = ev.pat_slip;
    cnt_inc[C_SYNC_LOSS] = sync_loss_ev;
    cnt_inc[C_LOS_ALARM] = live.los & ~live_prev_r.los;
    // Bit total is the denominator of the code error rate
    cnt_inc[C_RX_BITS] = rx_rise & ~live.los;
    cnt_inc[C_FRAME_SLIP] = frame_slip_ev;
  end

  for (genvar i = 0; i < NUM_CNT; i++) begin : g_cnt
    always_ff @(posedge clock) begin
      if (sys_rst || restart) begin
        cnt_r[i] <= '0;
      end else if (cnt_inc[i]) begin
        cnt_r[i] <= cnt_r[i] + 32'h1;
      end
    end
  end

  // ****************************************************************
  // All-clear indication
  // ****************************************************************
  logic err_nz;

  always_comb begin
    err_nz = 1'b0;
    for (int j = 0; j < NUM_CNT; j++) begin
      err_nz = err_nz | (ERR_CNT_MASK[j] & (cnt_r[j] != '0));
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      all_clear <= 1'b0;
    end else begin
      all_clear <= ~err_nz & ~|(hist_r & HIST_BAD) & (max_dev_r <= TOL_PPM);
    end
  end

  // ****************************************************************
  // Interrupts
  // ****************************************************************
  logic oot_prev_r;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      oot_prev_r <= 1'b0;
    end else begin
      oot_prev_r <= oot_r;
    end
  end

  always_comb begin
    irq_ev = '0;
    irq_ev[I_LOS] = live.los & ~live_prev_r.los;
    irq_ev[I_LOF] = live.lof & ~live_prev_r.lof;
    irq_ev[I_SYNC_LOSS] = sync_loss_ev;
    irq_ev[I_ERR] = |{ev.code_err, ev.crc_err, ev.ebit_err, ev.pat_err, ev.pat_slip};
    irq_ev[I_OOT] = oot_r & ~oot_prev_r;
    irq_ev[I_SLIP] = frame_slip_ev;
  end

  // A new event wins over a write-one-to-clear in the same cycle
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      irq_st_r <= '0;
    end else if (wr_en & (paddr == A_IRQ_ST)) begin
      irq_st_r <= (irq_st_r & ~pwdata[IRQ_W-1:0]) | irq_ev;
    end else begin
      irq_st_r <= irq_st_r | irq_ev;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_st_r & irq_mask_r);
    end
  end

endmodule : e1_perf_monitor

// file: verification/e1_line_model.sv
// Behavioural model of the receive line and the reference circuit
`timescale 1ns/1ps
module e1_line_model import e1_mon_pkg::*; (
  input wire logic rx_run,
  input wire logic ref_run,
  input wire logic [7:0] rx_half,
  input wire ev_t ev_req,
  output logic rx_clk_pin,
  output logic ref_clk_pin,
  output ev_t ev_out
);
  // ********************
  // Clocks and strobes
  // ********************
  // Odd offsets keep every line edge away from the system clock edges
  initial begin
    rx_clk_pin = 1'b0;
    #7;
    forever begin
      #(rx_half);
      if (rx_run) rx_clk_pin = ~rx_clk_pin;
    end
  end
  initial begin
    ref_clk_pin = 1'b0;
    #3;
    forever begin
      #80;
      if (ref_run) ref_clk_pin = ~ref_clk_pin;
    end
  end
  initial ev_out = '0;
  // Strobes change on the falling edge and stand one full bit
  always @(negedge rx_clk_pin) ev_out <= ev_req;
endmodule : e1_line_model

// file: verification/e1_mon_chk.sv
// Port-level assertion checker for the E1 performance monitor
`timescale 1ns/1ps
module e1_mon_chk import e1_mon_pkg::*; (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rx_clk_pin,
  input wire logic ref_clk_pin,
  input wire logic ref_los,
  input wire live_t live_in,
  input wire ev_t ev_in,
  input wire logic irq,
  input wire logic all_clear
);
  // ********************
  // Properties
  // ********************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable && pready;
  endsequence
  // Strobes are held a whole bit, so they are still there when the edge is seen
  sequence bit_err_s;
    $rose(rx_clk_pin) && (ev_in.code_err || ev_in.pat_err);
  endsequence
  AST_READY_AFTER_SETUP: assert property (setup_s |=> access_s)
    else $error("no ready after setup");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("slave error without ready");
  AST_UNMAPPED_ZERO: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("unmapped read data not zero");
  AST_CTRL_READ_ZERO: assert property (pready && !pwrite && paddr == A_CTRL |-> prdata == 32'h0)
    else $error("control read not zero");
  AST_RESET_QUIET: assert property (disable iff (1'b0) sys_rst |=> !pready && !irq && !all_clear)
    else $error("outputs active after reset");
  AST_LOS_BLOCKS_CLEAR: assert property (live_in.los |-> ##[1:8] !all_clear)
    else $error("all clear kept during signal loss");
  AST_ERR_BLOCKS_CLEAR: assert property (bit_err_s |-> ##[1:12] !all_clear)
    else $error("all clear kept after bit error");
endmodule : e1_mon_chk

bind e1_perf_monitor e1_mon_chk chk_u (.clock, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .rx_clk_pin, .ref_clk_pin, .ref_los, .live_in, .ev_in, .irq, .all_clear);

// file: verification/e1_performance_monitor_test.sv
// Self-checking bench for the E1 performance monitor
`timescale 1ns/1ps
module e1_performance_monitor_test import e1_mon_pkg::*;;
  // ********************
  // Stimulus and checking
  // ********************
  logic clock, sys_rst, psel, penable, pwrite, pready, pslverr, ref_los, irq, all_clear;
  logic rx_clk_pin, ref_clk_pin, rx_run, ref_run, rerr;
  logic [AW-1:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [7:0] rx_half;
  live_t live_in;
  ev_t ev_in, ev_req;
  int mismatches, comparisons, cyc;

  e1_perf_monitor #(.SEC_CYCLES(32'h3e8), .NOM_BITS(32'h7d)) dut_u (.clock, .sys_rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .rx_clk_pin, .ref_clk_pin, .ref_los, .live_in, .ev_in, .irq,
    .all_clear);
  e1_line_model line_u (.rx_run, .ref_run, .rx_half, .ev_req, .rx_clk_pin, .ref_clk_pin, .ev_out(ev_in));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  always @(posedge clock) cyc <= sys_rst ? 0 : cyc + 1;

  task automatic complete_run();
    if (mismatches == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [AW-1:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do @(posedge clock);
    while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb

  task automatic rd(input logic [AW-1:0] a, input logic [31:0] e, input string what);
    apb(1'b0, a, 32'h0);
    check(what, rdat, e);
  endtask : rd

  function automatic logic [AW-1:0] ca(input int i);
    return A_CNT_BASE + AW'(4 * i);
  endfunction : ca

  // Mid-second keeps a restart or a pulse clear of the one-second tick
  task automatic wait_mid();
    do @(posedge clock);
    while (cyc % 1000 != 500);
  endtask : wait_mid

  task automatic strobe(input ev_t v, input int n);
    ev_req <= v;
    repeat (n) @(negedge rx_clk_pin);
    @(posedge clock);
    ev_req <= '0;
    repeat (3) @(negedge rx_clk_pin);
    @(posedge clock);
  endtask : strobe

  task automatic run_edges(input logic on_rx, input int n);
    if (on_rx) begin
      rx_run <= 1'b1;
      repeat (n) @(posedge rx_clk_pin);
    end else begin
      ref_run <= 1'b1;
      repeat (n) @(posedge ref_clk_pin);
    end
    @(posedge clock);
    rx_run <= 1'b0;
    ref_run <= 1'b0;
    repeat (8) @(posedge clock);
  endtask : run_edges

  task automatic t_freq();
    repeat (2100) @(posedge clock);
    check("all_clear", {31'h0, all_clear}, 32'h1);
    rd(A_LIVE, 32'h400, "live nominal");
    rx_half <= 8'h28;
    repeat (2100) @(posedge clock);
    apb(1'b0, A_DEV, 32'h0);
    check("dev fast", {31'h0, rdat == 32'h3c || rdat == 32'h3d}, 32'h1);
    rd(A_LIVE, 32'h800, "live fast");
    rx_half <= 8'h50;
    repeat (2100) @(posedge clock);
    rd(A_LIVE, 32'h0, "live back");
    apb(1'b0, A_MAX_DEV, 32'h0);
    check("max dev", {31'h0, rdat == 32'h3c || rdat == 32'h3d}, 32'h1);
    wait_mid();
    apb(1'b1, A_CTRL, 32'h1);
    rd(A_MAX_DEV, 32'h0, "max dev cleared");
  endtask : t_freq

  task automatic t_events();
    int ci [8] = '{13, 12, 11, 10, 9, 8, 7, 2};
    strobe(ev_t'(8'h60), 2);
    live_in.fas_sync <= 1'b1;
    repeat (8) @(posedge clock);
    for (int i = 7; i >= 0; i--) begin
      strobe(ev_t'(8'h01 << i), 3);
    end
    for (int i = 0; i < 8; i++) begin
      rd(ca(ci[i]), (i == 1) ? 32'h1 : 32'h3, "event count");
    end
  endtask : t_events

  task automatic t_sync();
    live_in.sequence_sync_lost <= 1'b1;
    repeat (8) @(posedge clock);
    apb(1'b1, A_CTRL, 32'h1);
    repeat (8) @(posedge clock);
    live_in.sequence_sync_lost <= 1'b0;
    repeat (8) @(posedge clock);
    live_in.sequence_sync_lost <= 1'b1;
    repeat (8) @(posedge clock);
    live_in.sequence_sync_lost <= 1'b0;
    rd(ca(C_SYNC_LOSS), 32'h1, "sync losses");
  endtask : t_sync

  task automatic t_seconds();
    int lb [6] = '{9, 8, 3, 2, 1, 0};
    int ci [6] = '{0, 1, 3, 4, 5, 6};
    for (int k = 0; k < 6; k++) begin
      wait_mid();
      live_in[lb[k]] <= 1'b1;
      repeat (1000) @(posedge clock);
      live_in[lb[k]] <= 1'b0;
      wait_mid();
      rd(ca(ci[k]), 32'h2, "second count");
    end
    rd(ca(C_LOS_ALARM), 32'h1, "los alarms");
  endtask : t_seconds

  task automatic t_hist();
    wait_mid();
    live_in <= live_t'(10'h3ff);
    repeat (8) @(posedge clock);
    live_in <= '0;
    repeat (8) @(posedge clock);
    rd(A_HIST, 32'h3ff, "history");
    apb(1'b1, A_CTRL, 32'h1);
    rd(A_HIST, 32'h0, "history cleared");
    rd(ca(C_LOS_SEC), 32'h0, "counter cleared");
  endtask : t_hist

  task automatic t_slip();
    logic [31:0] base;
    rx_run <= 1'b0;
    ref_run <= 1'b0;
    ref_los <= 1'b1;
    repeat (8) @(posedge clock);
    ref_los <= 1'b0;
    repeat (8) @(posedge clock);
    rd(A_BIT_SLIP, 32'h0, "slip zeroed");
    apb(1'b0, ca(C_RX_BITS), 32'h0);
    base = rdat;
    run_edges(1'b1, 300);
    rd(ca(C_RX_BITS), base + 32'h12c, "received bits");
    rd(A_BIT_SLIP, 32'h2c, "slip wrapped");
    rd(ca(C_FRAME_SLIP), 32'h1, "frame slips");
    run_edges(1'b0, 50);
    rd(A_BIT_SLIP, 32'hffff_fffa, "slip negative");
    live_in.los <= 1'b1;
    repeat (8) @(posedge clock);
    rd(A_BIT_SLIP, 32'h0, "slip on los");
    live_in.los <= 1'b0;
    rx_run <= 1'b1;
    ref_run <= 1'b1;
  endtask : t_slip

  task automatic t_irq();
    apb(1'b1, A_IRQ_MASK, 32'h0);
    apb(1'b1, A_IRQ_ST, 32'h3f);
    strobe(ev_t'(8'h80), 1);
    check("irq masked", {31'h0, irq}, 32'h0);
    apb(1'b0, A_IRQ_ST, 32'h0);
    check("irq status", {31'h0, rdat[I_ERR]}, 32'h1);
    apb(1'b1, A_IRQ_MASK, 32'h8);
    repeat (3) @(posedge clock);
    check("irq raised", {31'h0, irq}, 32'h1);
    apb(1'b1, A_IRQ_ST, 32'h8);
    repeat (3) @(posedge clock);
    check("irq cleared", {31'h0, irq}, 32'h0);
    rd(A_CTRL, 32'h0, "control");
    apb(1'b0, 12'h088, 32'h0);
    check("unmapped", {rerr, rdat[30:0]}, 32'h8000_0000);
  endtask : t_irq

  initial begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    ref_los = 1'b0;
    live_in = '0;
    ev_req = '0;
    rx_half = 8'h50;
    rx_run = 1'b1;
    ref_run = 1'b1;
    mismatches = 0;
    comparisons = 0;
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    t_freq();
    t_events();
    t_sync();
    t_seconds();
    t_hist();
    t_slip();
    t_irq();
    complete_run();
  end

  // The sequence needs about 28500 cycles
  initial begin
    #1000000;
    mismatches++;
    complete_run();
  end
endmodule : e1_performance_monitor_test
